//--- logic/latency_cfg_defines.svh
// field positions, codes and reset values of the latency and extended configuration block
`ifndef LATENCY_CFG_DEFINES_SVH
`define LATENCY_CFG_DEFINES_SVH
// pin bus widths
`define ADDR_W       14
`define BANK_W       3
`define EXT_W        17
`define PIN_W        24
// pending-edge shift widths
`define PEND_W       16
`define AL_W         8
`define ONE_PEND     16'h0001
// positions inside the synchronised pin vector
`define P_LINK       0
`define P_CKE        1
`define P_CS_N       2
`define P_WE_N       5
`define P_TERM       6
`define P_BANK_LSB   7
`define P_BANK_MSB   9
`define P_ADDR_LSB   10
`define P_ADDR_MSB   23
// base mode word fields
`define MR_CL_LSB    4
`define MR_CL_MSB    6
`define MR_LOOP_RST  8
// extended mode word fields
`define EX_LOOP_DIS  0
`define EX_DRIVE     1
`define EX_TERM_LO   2
`define EX_AL_LSB    3
`define EX_AL_MSB    5
`define EX_TERM_HI   6
`define EX_CAL_LSB   7
`define EX_CAL_MSB   9
`define EX_STB_N_DIS 10
`define EX_COPY_EN   11
`define EX_OUT_DIS   12
// legal ranges and reset values
`define CL_MIN       3'h3
`define CL_MAX       3'h7
`define AL_MAX       3'h6
`define CL_RESET     3'h3
`define EXT_RESET    17'h00000
`define RL_RESET     4'h3
`define WL_RESET     4'h2
`define WL_GAP       4'h1
// {bank_select_high, bank_select_low} targets
`define BANK_BASE    2'h0
`define BANK_EXT     2'h2
// {cs_n, ras_n, cas_n, we_n} command codes
`define CMD_LOAD     4'h0
`define CMD_REFRESH  4'h1
`define CMD_WRITE    4'h4
`define CMD_READ     4'h5
// termination codes {high, low}
`define TERM_OFF     2'h0
// command buffer
`define FIFO_DEPTH   2'h2
`endif

//--- logic/latency_cfg_pkg.sv
// types shared by the latency and extended configuration block
package latency_cfg_pkg;
   typedef enum logic [1:0] {
      ST_RUN          = 2'b01,
      ST_SELF_REFRESH = 2'b10
   } link_state_type;

   typedef struct packed {
      logic is_write;
   } array_cmd_type;
endpackage : latency_cfg_pkg

//--- logic/cmd_stream_if.sv
// valid/ready stream of internally issued column commands
`timescale 1ns/100ps
interface cmd_stream_if;
   logic                          valid;
   logic                          ready;
   latency_cfg_pkg::array_cmd_type data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : cmd_stream_if

//--- logic/pin_sync.sv
// two-flop synchroniser for every memory pin
`timescale 1ns/100ps
`include "latency_cfg_defines.svh"
module pin_sync (
   // clock and reset
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   // pins
   input  wire logic [`PIN_W-1:0]  pins_in,
   output logic      [`PIN_W-1:0]  pins_out
);
   typedef struct packed {
      logic [`PIN_W-1:0] s1;
      logic [`PIN_W-1:0] s2;
   } sync_state_type;

   sync_state_type s_reg;
   sync_state_type s_next;

   // first stage feeds only the second
   always_comb begin
      s_next    = s_reg;
      s_next.s1 = pins_in;
      s_next.s2 = s_reg.s1;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pins_out = s_reg.s2;
endmodule : pin_sync

//--- logic/cmd_fifo.sv
// two-entry buffer for issued column commands
`timescale 1ns/100ps
`include "latency_cfg_defines.svh"
module cmd_fifo (
   // clock and reset
   input  wire logic   clk_in,
   input  wire logic   rst_n_in,
   // streams
   cmd_stream_if.snk   fill,
   cmd_stream_if.src   drain
);
   typedef struct packed {
      latency_cfg_pkg::array_cmd_type [1:0] mem;
      logic                                 wptr;
      logic                                 rptr;
      logic [1:0]                           count;
   } fifo_state_type;

   fifo_state_type s_reg;
   fifo_state_type s_next;
   logic           push;
   logic           pop;

   // honest full and empty from the count
   assign fill.ready  = (s_reg.count != `FIFO_DEPTH);
   assign drain.valid = (s_reg.count != 2'h0);
   assign drain.data  = s_reg.mem[s_reg.rptr];
   assign push        = fill.valid & fill.ready;
   assign pop         = drain.valid & drain.ready;

   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wptr] = fill.data;
         s_next.wptr            = ~s_reg.wptr;
      end
      if (pop) begin
         s_next.rptr = ~s_reg.rptr;
      end
      s_next.count = 2'(s_reg.count + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : cmd_fifo

//--- logic/sdram_latency_ext_mode_config.sv
// latency and extended mode configuration held inside the memory device
// Notes on behaviour
// - read column delay is a three-bit field, whole cycles 3 to 7 only.
// - with no extra delay, first read data aligns with link edge n plus delay.
// - extended word holds until reloaded; reload never touches array contents.
// - self refresh entry disables the loop; exit re-enables and resets it.
// - extended bit 1 picks full or reduced drive strength on all outputs.
// - extended bit 10 low drives strobe complement; high runs single-ended.
// - copy strobe complement only when copy strobe and strobe complement enabled.
// - bit 11 makes the copy strobe follow the data strobe on reads only.
// - extended bit 12 high disables all data and strobe outputs.
// - extended bits 6 and 2 pick one of three termination values.
// - termination pin switches termination, only outside self refresh.
// - extra delay field sets posted delay 0 to 6 clocks.
// - commands accepted early are held for the extra delay, then issued.
// - read total is extra plus column delay; write total one less.
// - base loop reset bit clears itself once the reset is done.
// - load with bank low 0 and bank high 1 writes the extended word.
// - load with both bank bits low writes the base word.
`timescale 1ns/100ps
`include "latency_cfg_defines.svh"
module sdram_latency_ext_mode_config (
   // clock and reset
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   // memory pins from the controller
   input  wire logic               link_clk_in,
   input  wire logic               cke_in,
   input  wire logic               cs_n_in,
   input  wire logic               ras_n_in,
   input  wire logic               cas_n_in,
   input  wire logic               we_n_in,
   input  wire logic [`BANK_W-1:0] bank_in,
   input  wire logic [`ADDR_W-1:0] addr_in,
   input  wire logic               term_ctrl_in,
   // configuration view
   output logic [3:0]              read_total_delay_out,
   output logic [3:0]              write_total_delay_out,
   output logic [2:0]              read_column_delay_out,
   output logic [2:0]              posted_extra_delay_out,
   output logic [2:0]              driver_calibration_out,
   output logic [1:0]              termination_value_out,
   output logic                    termination_on_out,
   output logic                    loop_enable_out,
   output logic                    loop_reset_out,
   output logic                    drive_reduced_out,
   output logic                    strobe_complement_en_out,
   output logic                    read_strobe_copy_en_out,
   output logic                    read_strobe_copy_n_en_out,
   output logic                    outputs_en_out,
   output logic                    self_refresh_out,
   output logic                    reserved_code_out,
   // data timing marks
   output logic                    read_data_start_out,
   output logic                    write_data_start_out,
   // issued command stream
   output logic                    array_cmd_valid_out,
   output logic                    array_cmd_write_out,
   input  wire logic               array_cmd_ready_in,
   output logic                    cmd_accept_ready_out
);
   typedef struct packed {
      latency_cfg_pkg::link_state_type st;
      logic                            link_q;
      logic [2:0]                      cl;
      logic [`EXT_W-1:0]               ext;
      logic                            loop_rst;
      logic [3:0]                      rl;
      logic [3:0]                      wl;
      logic [`PEND_W-1:0]              rd_pend;
      logic [`PEND_W-1:0]              wr_pend;
      logic [`AL_W-1:0]                iss_rd;
      logic [`AL_W-1:0]                iss_wr;
      logic                            rd_start;
      logic                            wr_start;
      logic                            reserved;
   } cfg_state_type;

   cfg_state_type     s_reg;
   cfg_state_type     s_next;
   logic [`PIN_W-1:0] pins;
   logic              link_edge;
   logic [3:0]        cmd;
   logic [1:0]        bank_sel;
   logic [2:0]        new_cl;
   logic [2:0]        new_al;
   logic              cmd_live;
   logic              base_load;
   logic              ext_load;
   logic              rd_now;
   logic              wr_now;
   logic              push_rd;
   logic              push_wr;

   cmd_stream_if fill_if ();
   cmd_stream_if drain_if ();

   // total delay from column and extra parts
   function automatic logic [3:0] total_delay(input logic [2:0] cl, input logic [2:0] al);
      total_delay = 4'({1'b0, cl} + {1'b0, al});
   endfunction : total_delay

   // marker that surfaces after the given number of link edges
   function automatic logic [`PEND_W-1:0] mark_at(input logic [3:0] edges);
      mark_at = `ONE_PEND << edges;
   endfunction : mark_at

   // marker for the extra-delay shift; only called with a nonzero extra delay, so no underflow
   function automatic logic [`AL_W-1:0] issue_mark(input logic [2:0] al);
      logic [`PEND_W-1:0] wide;
      wide       = mark_at(4'({1'b0, al} - `WL_GAP));
      issue_mark = wide[`AL_W-1:0];
   endfunction : issue_mark

   // every pin crosses two flops first; link clock edges are found afterwards
   pin_sync i_pin_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .pins_in  ({addr_in, bank_in, term_ctrl_in, we_n_in, cas_n_in, ras_n_in, cs_n_in, cke_in, link_clk_in}),
      .pins_out (pins)
   );

   // command decode on the sampled rising link edge
   assign link_edge = pins[`P_LINK] & ~s_reg.link_q;
   // packed as {cs_n, ras_n, cas_n, we_n}, the order the command codes are written in
   assign cmd       = {pins[`P_CS_N], pins[`P_CS_N+1], pins[`P_CS_N+2], pins[`P_WE_N]};
   assign bank_sel  = pins[`P_BANK_LSB+1:`P_BANK_LSB];
   assign new_cl    = pins[`P_ADDR_LSB+`MR_CL_MSB:`P_ADDR_LSB+`MR_CL_LSB];
   assign new_al    = pins[`P_ADDR_LSB+`EX_AL_MSB:`P_ADDR_LSB+`EX_AL_LSB];
   assign cmd_live  = link_edge & pins[`P_CKE] & (s_reg.st == latency_cfg_pkg::ST_RUN);
   // reserved latency codes leave the stored word untouched
   assign base_load = cmd_live & (cmd == `CMD_LOAD) & (bank_sel == `BANK_BASE)
                      & (new_cl >= `CL_MIN) & (new_cl <= `CL_MAX);
   assign ext_load  = cmd_live & (cmd == `CMD_LOAD) & (bank_sel == `BANK_EXT)
                      & (new_al <= `AL_MAX);
   assign rd_now    = cmd_live & (cmd == `CMD_READ);
   assign wr_now    = cmd_live & (cmd == `CMD_WRITE);

   // a held command leaves when its marker reaches the bottom of the extra-delay shift
   assign push_rd = link_edge & (s_reg.iss_rd[0] | (rd_now & (s_reg.ext[`EX_AL_MSB:`EX_AL_LSB] == 3'h0)));
   assign push_wr = link_edge & (s_reg.iss_wr[0] | (wr_now & (s_reg.ext[`EX_AL_MSB:`EX_AL_LSB] == 3'h0)));
   assign fill_if.valid         = push_rd | push_wr;
   assign fill_if.data.is_write = ~push_rd;

   always_comb begin
      s_next          = s_reg;
      s_next.link_q   = pins[`P_LINK];
      s_next.rd_start = 1'b0;
      s_next.wr_start = 1'b0;
      s_next.loop_rst = 1'b0;
      if (link_edge) begin
         s_next.rd_start = s_reg.rd_pend[0];
         s_next.wr_start = s_reg.wr_pend[0];
         s_next.rd_pend  = s_reg.rd_pend >> 1;
         s_next.wr_pend  = s_reg.wr_pend >> 1;
         s_next.iss_rd   = s_reg.iss_rd >> 1;
         s_next.iss_wr   = s_reg.iss_wr >> 1;
         case (s_reg.st)
            latency_cfg_pkg::ST_RUN: begin
               if (!pins[`P_CKE] && cmd == `CMD_REFRESH) begin
                  s_next.st = latency_cfg_pkg::ST_SELF_REFRESH;
               end
            end
            latency_cfg_pkg::ST_SELF_REFRESH: begin
               if (pins[`P_CKE]) begin
                  s_next.st       = latency_cfg_pkg::ST_RUN;
                  s_next.loop_rst = 1'b1;
               end
            end
            default: begin
               s_next.st = latency_cfg_pkg::ST_RUN;
            end
         endcase
         if (cmd_live && cmd == `CMD_LOAD) begin
            s_next.reserved = ~(base_load | ext_load) & (bank_sel == `BANK_BASE || bank_sel == `BANK_EXT);
         end
         if (base_load) begin
            s_next.cl       = new_cl;
            s_next.loop_rst = pins[`P_ADDR_LSB+`MR_LOOP_RST];
            s_next.rl       = total_delay(new_cl, s_reg.ext[`EX_AL_MSB:`EX_AL_LSB]);
            s_next.wl       = 4'(total_delay(new_cl, s_reg.ext[`EX_AL_MSB:`EX_AL_LSB]) - `WL_GAP);
         end
         if (ext_load) begin
            s_next.ext = {pins[`P_BANK_MSB:`P_BANK_LSB], pins[`P_ADDR_MSB:`P_ADDR_LSB]};
            s_next.rl  = total_delay(s_reg.cl, new_al);
            s_next.wl  = 4'(total_delay(s_reg.cl, new_al) - `WL_GAP);
         end
         // markers use the settings latched before this edge
         if (rd_now) begin
            s_next.rd_pend = s_next.rd_pend | mark_at(4'(s_reg.rl - `WL_GAP));
            if (s_reg.ext[`EX_AL_MSB:`EX_AL_LSB] != 3'h0) begin
               s_next.iss_rd = s_next.iss_rd
                               | issue_mark(s_reg.ext[`EX_AL_MSB:`EX_AL_LSB]);
            end
         end
         if (wr_now) begin
            s_next.wr_pend = s_next.wr_pend | mark_at(4'(s_reg.wl - `WL_GAP));
            if (s_reg.ext[`EX_AL_MSB:`EX_AL_LSB] != 3'h0) begin
               s_next.iss_wr = s_next.iss_wr
                               | issue_mark(s_reg.ext[`EX_AL_MSB:`EX_AL_LSB]);
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_reg <= '{st: latency_cfg_pkg::ST_RUN, link_q: 1'b0, cl: `CL_RESET, ext: `EXT_RESET,
                    loop_rst: 1'b0, rl: `RL_RESET, wl: `WL_RESET, rd_pend: '0, wr_pend: '0,
                    iss_rd: '0, iss_wr: '0, rd_start: 1'b0, wr_start: 1'b0, reserved: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // a full buffer shows at cmd_accept_ready_out; a command issued then is lost
   cmd_fifo i_cmd_fifo (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .fill     (fill_if.snk),
      .drain    (drain_if.src)
   );
   assign drain_if.ready       = array_cmd_ready_in;
   assign array_cmd_valid_out  = drain_if.valid;
   assign array_cmd_write_out  = drain_if.data.is_write;
   assign cmd_accept_ready_out = fill_if.ready;

   // configuration view, all from stored words except termination_on_out, which also takes the termination pin
   assign read_total_delay_out      = s_reg.rl;
   assign write_total_delay_out     = s_reg.wl;
   assign read_column_delay_out     = s_reg.cl;
   assign posted_extra_delay_out    = s_reg.ext[`EX_AL_MSB:`EX_AL_LSB];
   assign driver_calibration_out    = s_reg.ext[`EX_CAL_MSB:`EX_CAL_LSB];
   assign self_refresh_out          = (s_reg.st == latency_cfg_pkg::ST_SELF_REFRESH);
   assign loop_enable_out           = ~s_reg.ext[`EX_LOOP_DIS] & ~self_refresh_out;
   assign loop_reset_out            = s_reg.loop_rst;
   assign drive_reduced_out         = s_reg.ext[`EX_DRIVE];
   assign outputs_en_out            = ~s_reg.ext[`EX_OUT_DIS];
   assign strobe_complement_en_out  = ~s_reg.ext[`EX_STB_N_DIS] & outputs_en_out;
   // copy strobe only matters on x8 parts and only during reads
   assign read_strobe_copy_en_out   = s_reg.ext[`EX_COPY_EN] & outputs_en_out;
   assign read_strobe_copy_n_en_out = read_strobe_copy_en_out & strobe_complement_en_out;
   assign termination_value_out     = {s_reg.ext[`EX_TERM_HI], s_reg.ext[`EX_TERM_LO]};
   // pin is ignored in self refresh, where the loop and termination are parked
   assign termination_on_out        = pins[`P_TERM] & (termination_value_out != `TERM_OFF)
                                      & ~self_refresh_out;
   assign reserved_code_out         = s_reg.reserved;
   assign read_data_start_out       = s_reg.rd_start;
   assign write_data_start_out      = s_reg.wr_start;

   // checks on the stored settings and their timing effects
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_cl_legal_range: assert property (s_reg.cl >= `CL_MIN && s_reg.cl <= `CL_MAX)
      else $error("column delay outside 3..7");
   a_al_legal_range: assert property (s_reg.ext[`EX_AL_MSB:`EX_AL_LSB] <= `AL_MAX)
      else $error("extra delay above 6");
   a_rl_sum_holds: assert property (s_reg.rl == total_delay(s_reg.cl, s_reg.ext[`EX_AL_MSB:`EX_AL_LSB]))
      else $error("read total is not extra plus column delay");
   a_wl_one_less: assert property (s_reg.wl == 4'(s_reg.rl - `WL_GAP))
      else $error("write total is not read total minus one");
   a_read_data_due: assert property (rd_now |-> ##[1:200] s_reg.rd_start)
      else $error("read data start mark missing");
   a_ext_word_hold: assert property (!ext_load |=> $stable(s_reg.ext))
      else $error("extended word changed without a load");
   a_base_word_hold: assert property (!base_load |=> $stable(s_reg.cl))
      else $error("column delay changed without a load");
   a_ext_load_takes: assert property (ext_load |=> s_reg.ext == {$past(pins[`P_BANK_MSB:`P_BANK_LSB]),
                                      $past(pins[`P_ADDR_MSB:`P_ADDR_LSB])})
      else $error("extended load not stored");
   a_write_data_due: assert property (wr_now |-> ##[1:200] s_reg.wr_start)
      else $error("write data start mark missing");
   // a stalled receiver must see the same entry until it takes it
   a_stream_hold: assert property (array_cmd_valid_out && !array_cmd_ready_in |=> array_cmd_valid_out
                                   && $stable(array_cmd_write_out))
      else $error("issued command dropped or changed while stalled");
   a_loop_sr_off: assert property (self_refresh_out |-> !loop_enable_out && !termination_on_out)
      else $error("loop or termination active in self refresh");
   a_sr_exit_reset: assert property ($past(self_refresh_out) && !self_refresh_out |-> loop_reset_out)
      else $error("no loop reset on self refresh exit");
   a_loop_self_clear: assert property (loop_reset_out |=> !loop_reset_out)
      else $error("loop reset bit did not clear");
   a_copy_n_gate: assert property (read_strobe_copy_n_en_out |-> read_strobe_copy_en_out
                                   && strobe_complement_en_out && s_reg.ext[`EX_COPY_EN])
      else $error("copy complement enabled without both enables");
   a_out_disable: assert property (s_reg.ext[`EX_OUT_DIS] |-> !(outputs_en_out || strobe_complement_en_out
                                   || read_strobe_copy_en_out))
      else $error("outputs on while disabled");

   c_read_data: cover property (rd_now ##[1:200] s_reg.rd_start);
   c_write_data: cover property (wr_now ##[1:200] s_reg.wr_start);
   c_sr_round: cover property (self_refresh_out ##[1:400] loop_reset_out);
   c_posted_issue: cover property (ext_load ##[1:1000] (fill_if.valid && s_reg.ext[`EX_AL_MSB:`EX_AL_LSB] != 3'h0));
   c_buffer_full: cover property (!cmd_accept_ready_out ##[1:1000] cmd_accept_ready_out);
endmodule : sdram_latency_ext_mode_config

//--- tb/ctrl_model.sv
// memory controller model that issues commands on the link pins
`timescale 1ns/100ps
module ctrl_model (
   // clock
   input  wire logic clk_in,
   // link pins
   output logic        link_clk_out,
   output logic        cke_out,
   output logic [3:0]  cmd_out,
   output logic [2:0]  bank_out,
   output logic [13:0] addr_out,
   // link edge count, time base for latency marks
   output int          edge_out
);
   // the memory clock runs free, unrelated in phase to clk_in
   initial begin
      link_clk_out = 1'b0;
      cke_out = 1'b1;
      cmd_out = 4'hf;
      bank_out = 3'h0;
      addr_out = 14'h0000;
      forever #62.5 link_clk_out = ~link_clk_out; // slow link, but no auto refresh is ever issued
   end
   // count rising link edges
   always @(posedge link_clk_out) begin
      edge_out <= edge_out + 1;
   end
   // one command: set up mid-cycle so pins are stable well around the taking edge
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic k,
                        output int n);
      @(negedge link_clk_out);
      @(posedge clk_in);
      cke_out <= k;
      cmd_out <= c;
      bank_out <= b;
      addr_out <= a;
      @(posedge link_clk_out);
      #1 n = edge_out;
      @(negedge link_clk_out);
      @(posedge clk_in);
      cmd_out <= 4'hf; // deselect between commands
      addr_out <= ~a; // released address shows no stale value
   endtask : issue
endmodule : ctrl_model

//--- tb/test_sdram_latency_ext_mode_config.sv
// self-checking bench for the latency and extended configuration block
`timescale 1ns/100ps
`include "latency_cfg_defines.svh"
module test_sdram_latency_ext_mode_config;
   logic        clk_in, rst_n_in, link_clk, cke, term, ready, hold;
   logic [3:0]  cmd, rtd, wtd, rl;
   logic [2:0]  bank, cld, ped, cal, al;
   logic [13:0] addr, a;
   logic [1:0]  tv;
   logic [31:0] rnd, ev;
   logic        ton, len, lrs, drr, sce, rce, rcn, oen, srf, rsv, rds, wds, avl, awr, acc;
   int          edge_n, n, miscompares, check_count, lr_seen, rd_q[$], wr_q[$];
   logic        st_q[$];
   ctrl_model i_ctrl_model (.clk_in(clk_in), .link_clk_out(link_clk), .cke_out(cke), .cmd_out(cmd),
      .bank_out(bank), .addr_out(addr), .edge_out(edge_n));
   sdram_latency_ext_mode_config i_sdram_latency_ext_mode_config (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .link_clk_in(link_clk), .cke_in(cke), .cs_n_in(cmd[3]), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]),
      .we_n_in(cmd[0]), .bank_in(bank), .addr_in(addr), .term_ctrl_in(term), .read_total_delay_out(rtd),
      .write_total_delay_out(wtd), .read_column_delay_out(cld), .posted_extra_delay_out(ped),
      .driver_calibration_out(cal), .termination_value_out(tv), .termination_on_out(ton),
      .loop_enable_out(len), .loop_reset_out(lrs), .drive_reduced_out(drr), .strobe_complement_en_out(sce),
      .read_strobe_copy_en_out(rce), .read_strobe_copy_n_en_out(rcn), .outputs_en_out(oen),
      .self_refresh_out(srf), .reserved_code_out(rsv), .read_data_start_out(rds),
      .write_data_start_out(wds), .array_cmd_valid_out(avl), .array_cmd_write_out(awr),
      .array_cmd_ready_in(ready), .cmd_accept_ready_out(acc));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask : cmp_val
   task automatic cmp_edge(input string what, input int e, input int g);
      check_count++;
      if (g != e) begin
         miscompares++;
         $display("MISMATCH %s expected edge %0d seen edge %0d", what, e, g);
      end
   endtask : cmp_edge
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   // receiver stalls at random so the buffer sees backpressure
   always @(posedge clk_in) begin
      ready <= ~hold & 1'($urandom());
   end
   // results taken off the oldest note as they appear
   always @(posedge clk_in) begin
      if (rds) cmp_edge("read mark", rd_q.pop_front(), edge_n);
      if (wds) cmp_edge("write mark", wr_q.pop_front(), edge_n);
      if (avl && ready) cmp_val("issued kind", 32'(st_q.pop_front()), 32'(awr));
      if (lrs) lr_seen++;
   end
   initial begin
      #400000 miscompares++;
      tally_and_finish();
   end
   initial begin
      rst_n_in = 1'b0;
      term = 1'b0; // kept off until the extended word is loaded
      hold = 1'b0;
      rnd = $urandom(32'hf0d4);
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      cmp_val("reset view", 32'h0032_3130, {8'h0, rtd, wtd, 1'b0, cld, 3'h0, len, 2'h0, sce, oen, 1'b0, ped});
      i_ctrl_model.issue(`CMD_LOAD, 3'h2, 14'h0380, 1'b1, n);
      cmp_val("calibration", 32'h7, 32'(cal));
      for (int c = 3; c <= 7; c++) begin
         repeat (16) @(posedge link_clk); // idle before a load
         rnd = $urandom();
         al = (rnd[20:18] == 3'h7) ? 3'h6 : rnd[20:18];
         a = {1'b0, rnd[12:10], 3'h0, rnd[6], al, rnd[2:0]}; // reserved top bit zero
         i_ctrl_model.issue(`CMD_LOAD, 3'h2, a, 1'b1, n);
         i_ctrl_model.issue(`CMD_LOAD, 3'h0, {5'h0, 1'b1, 1'b0, 3'(c), 4'h0}, 1'b1, n);
         repeat (200) @(posedge link_clk);
         rl = 4'(al) + 4'(c);
         cmp_val("totals", {24'h0, rl, rl - 4'h1}, {24'h0, rtd, wtd});
         ev = {3'(c), al, 3'h0, a[6], a[2], ~a[0], a[1], ~a[10] & ~a[12], a[11] & ~a[12],
               ~a[10] & a[11] & ~a[12], ~a[12]};
         cmp_val("fields", ev, {cld, ped, cal, tv, len, drr, sce, rce, rcn, oen});
         // stream notes go in first: with no extra delay the entry can leave before the call returns
         st_q.push_back(1'b0);
         i_ctrl_model.issue(`CMD_READ, 3'h0, 14'h0, 1'b1, n);
         rd_q.push_back(n + int'(rl));
         st_q.push_back(1'b1);
         i_ctrl_model.issue(`CMD_WRITE, 3'h0, 14'h0, 1'b1, n);
         wr_q.push_back(n + int'(rl) - 1);
      end
      repeat (16) @(posedge link_clk);
      i_ctrl_model.issue(`CMD_LOAD, 3'h2, 14'h0044, 1'b1, n);
      repeat (8) @(posedge link_clk);
      @(posedge clk_in);
      term <= 1'b1;
      repeat (6) @(posedge clk_in);
      cmp_val("termination", 32'h7, {29'h0, tv, ton});
      term <= 1'b0;
      i_ctrl_model.issue(`CMD_LOAD, 3'h0, 14'h0020, 1'b1, n);
      cmp_val("reserved column", 32'h17, {27'h0, rsv, 1'b0, cld});
      i_ctrl_model.issue(`CMD_LOAD, 3'h2, 14'h0038, 1'b1, n);
      cmp_val("reserved extra", 32'h10, {27'h0, rsv, 1'b0, ped});
      i_ctrl_model.issue(`CMD_LOAD, 3'h1, 14'h0040, 1'b1, n);
      cmp_val("other bank", 32'h07, {27'h0, rsv, 1'b0, cld});
      i_ctrl_model.issue(`CMD_REFRESH, 3'h0, 14'h0, 1'b0, n);
      cmp_val("self refresh", 32'h2, {30'h0, srf, len});
      i_ctrl_model.issue(4'hf, 3'h0, 14'h0, 1'b1, n);
      cmp_val("refresh exit", 32'h1, {30'h0, srf, len});
      cmp_val("loop resets", 32'd6, lr_seen);
      hold <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         if (i < 2) st_q.push_back(1'b0);
         i_ctrl_model.issue(`CMD_READ, 3'h0, 14'h0, 1'b1, n);
         rd_q.push_back(n + 7);
      end
      cmp_val("buffer full", 32'h0, 32'(acc));
      hold <= 1'b0;
      repeat (60) @(posedge link_clk);
      cmp_val("drained", 32'h1, {31'h0, acc & ~avl});
      cmp_val("notes left", 32'h0, rd_q.size() + wr_q.size() + st_q.size());
      tally_and_finish();
   end
endmodule : test_sdram_latency_ext_mode_config
